// >>> rtl/gpx_top.sv
// The strobed register port was chosen for this implementation.
module gpx_top
  import gpx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  // device configuration levels
  input wire logic [1:0] pkg_variant_sel,
  input wire logic [1:0] primary_osc_config_field,
  input wire logic osc_output_function_bit,
  // pads, index 0 is port b up to 3 for port e
  input wire logic [3:0][15:0] pad_in,
  output logic [3:0][15:0] pad_out,
  output logic [3:0][15:0] pad_oe
);
  logic [15:0] addr_offs;
  logic addr_hit;
  logic [1:0] sel_port;
  gpx_fld_e sel_fld;
  logic osc_pins_ok;
  logic c15_ok;
  logic [15:0] osc_drop;
  logic is_64;
  logic is_small;
  logic [3:0][15:0] eff_mask;
  logic [3:0][15:0] dir_q;
  logic [3:0][15:0] lat_q;
  logic [3:0][15:0] odc_q;
  logic [3:0][15:0] pin_q;
  logic [15:0] rd_value;
  logic [15:0] rdata_reg;

  // address decode; odd byte addresses miss so a stray access is dropped
  assign addr_offs = bus_addr - GPX_BASE_ADDR;
  assign addr_hit = (bus_addr >= GPX_BASE_ADDR) &&
                    (addr_offs < GPX_MAP_SPAN) && !bus_addr[0];
  assign sel_port = addr_offs[4:3];
  assign sel_fld = gpx_fld_e'(addr_offs[2:1]);

  // oscillator gating of the two shared port c pins
  // oscillator field gate
  assign osc_pins_ok = (primary_osc_config_field == GPX_OSC_EXT_CLK) ||
                       (primary_osc_config_field == GPX_OSC_OFF);
  assign c15_ok = osc_pins_ok && osc_output_function_bit;
  assign osc_drop = (osc_pins_ok ? 16'h0000 : GPX_C_PIN12) |
                    (c15_ok ? 16'h0000 : GPX_C_PIN15);

  // package variant decode; an unknown code behaves as the full part
  assign is_64 = (pkg_variant_sel == GPX_VAR_64);
  assign is_small = is_64 || (pkg_variant_sel == GPX_VAR_80);

  // one port slice per port, each with its own implemented mask
  generate
    for (genvar i = 0; i < GPX_NPORT; i++)
    begin : g_port
      gpx_wr_s port_wr;
      gpx_pads_s port_pads;

      assign eff_mask[i] = GPX_IMPL_MASK[i] &
                           ~(is_64 ? GPX_DROP_64[i] : 16'h0000) &
                           ~(is_small ? GPX_DROP_80[i] : 16'h0000) &
                           ~((i == GPX_PORT_C) ? osc_drop : 16'h0000);

      // only the addressed port sees the write strobe
      assign port_wr.en = bus_wr && addr_hit && (sel_port == 2'(i));
      assign port_wr.fld = sel_fld;
      assign port_wr.data = bus_wdata;

      gpx_port #(
        .DIR_RESET(GPX_DIR_RST[i])
      ) u_port (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr(port_wr),
        .mask(eff_mask[i]),
        .pad_in(pad_in[i]),
        .dir_q(dir_q[i]),
        .lat_q(lat_q[i]),
        .odc_q(odc_q[i]),
        .pin_q(pin_q[i]),
        .pads(port_pads)
      );

      assign pad_out[i] = port_pads.out;
      assign pad_oe[i] = port_pads.oe;
    end
  endgenerate

  // read select; a miss returns zero rather than stale data
  always_comb
  begin
    rd_value = 16'h0000;
    if (addr_hit)
    begin
      case (sel_fld)
        FLD_DIR: rd_value = dir_q[sel_port];
        FLD_PIN: rd_value = pin_q[sel_port];
        FLD_LAT: rd_value = lat_q[sel_port];
        FLD_ODC: rd_value = odc_q[sel_port];
        default: rd_value = 16'h0000;
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 16'h0000;
    else if (bus_rd)
      rdata_reg <= rd_value;
    else
      rdata_reg <= 16'h0000;
  end

  assign bus_rdata = rdata_reg;

  // helper state for the checks below
  logic first_cycle_reg;
  logic [15:0] rd_mask;

  // marks the first edge after reset release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      first_cycle_reg <= 1'b1;
    else
      first_cycle_reg <= 1'b0;
  end

  assign rd_mask = addr_hit ? eff_mask[sel_port] : 16'h0000;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // a read never shows a bit outside the live mask
  unimpl_read_zero_a: assert property (
    bus_rd |=> (bus_rdata & ~$past(rd_mask)) == 16'h0000)
    else $error("unimplemented bit read as one");

  // a write to an absent bit leaves the stored value unchanged
  unimpl_write_keep_a: assert property (
    (bus_wr && addr_hit && sel_fld == FLD_ODC && sel_port == 2'd1 &&
     !is_small) ##2 (bus_rd && addr_hit && sel_fld == FLD_ODC &&
     sel_port == 2'd1 && !is_small)
    |=> bus_rdata[0] == 1'b0)
    else $error("port c bit 0 took a write");

  // directions of ports b, d and e, open drain and drive at the first edge after reset
  dir_reset_value_a: assert property (
    first_cycle_reg |-> (dir_q[0] == (GPX_DIR_RST[0] & eff_mask[0])) &&
      (dir_q[2] == (GPX_DIR_RST[2] & eff_mask[2])) &&
      (dir_q[3] == (GPX_DIR_RST[3] & eff_mask[3])) &&
      (odc_q == '0) && (pad_oe == '0))
    else $error("direction or open drain reset value wrong");

  // bad oscillator setting hides pins 12 and 15 of port c
  osc_pin_gate_a: assert property (
    !osc_pins_ok |-> (eff_mask[1] & (GPX_C_PIN12 | GPX_C_PIN15)) == 16'h0000
      && (pad_oe[1] & (GPX_C_PIN12 | GPX_C_PIN15)) == 16'h0000)
    else $error("oscillator pins of port c active");

  // pin 15 also needs the output function bit
  osc_fn_gate_a: assert property (
    (bus_rd && addr_hit && sel_port == 2'd1 && !osc_output_function_bit)
    |=> bus_rdata[15] == 1'b0)
    else $error("port c pin 15 readable without function bit");

  // good oscillator setting with the output function bit set lets both pins through
  osc_pin_open_a: assert property (
    c15_ok |-> (eff_mask[1] & (GPX_C_PIN12 | GPX_C_PIN15)) ==
      (GPX_C_PIN12 | GPX_C_PIN15))
    else $error("oscillator pins of port c masked wrongly");

  // small packages lose port c bits 2 and 4
  small_pkg_drop_a: assert property (
    is_small |-> (eff_mask[1] & 16'h0014) == 16'h0000 &&
      (pad_oe[1] & 16'h0014) == 16'h0000)
    else $error("port c bit 2 or 4 present on small package");

  // 64-pin package loses the extra bits of c, d and e
  pkg64_drop_a: assert property (
    is_64 |-> eff_mask[1][3:1] == 3'h0 && eff_mask[2][15:12] == 4'h0 &&
      eff_mask[3][9:8] == 2'h0 && eff_mask[3][7:0] == 8'hff)
    else $error("64-pin removal mask wrong");

  // an input pin is never driven
  input_no_drive_a: assert property (
    (bus_wr && addr_hit && sel_fld == FLD_DIR && sel_port == 2'd0 &&
     bus_wdata[0])
    |=> !pad_oe[0][0])
    else $error("input pin driven");

  // output pin follows a latch write, open drain never drives high
  latch_drive_a: assert property (
    (bus_wr && addr_hit && sel_fld == FLD_LAT && sel_port == 2'd2 &&
     dir_q[2][5] == 1'b0 && eff_mask[2][5])
    |=> pad_out[2][5] == $past(bus_wdata[5]) &&
        pad_oe[2][5] == !(odc_q[2][5] && pad_out[2][5]))
    else $error("output pin does not follow latch");

  // main scenarios
  drive_out_c: cover property (
    bus_wr && sel_fld == FLD_DIR ##1 (pad_oe != '0));
  open_drain_c: cover property (
    (odc_q[0] != 16'h0000) && (pad_out[0] != 16'h0000));
  osc_gate_c: cover property (
    bus_rd && sel_port == 2'd1 && !osc_pins_ok);
  pkg64_read_c: cover property (is_64 && bus_rd && sel_port == 2'd2);
endmodule

// >>> rtl/gpx_pkg.sv
package gpx_pkg;
  // register map, byte addresses as printed
  localparam logic [15:0] GPX_BASE_ADDR = 16'h02c8;
  localparam logic [15:0] GPX_MAP_SPAN = 16'h0020;
  localparam logic [15:0] PORT_B_DIRECTION = 16'h02c8;
  localparam logic [15:0] PORT_B_PIN_LEVEL = 16'h02ca;
  localparam logic [15:0] PORT_B_OUTPUT_LATCH = 16'h02cc;
  localparam logic [15:0] PORT_B_OPEN_DRAIN = 16'h02ce;
  localparam logic [15:0] PORT_C_DIRECTION = 16'h02d0;
  localparam logic [15:0] PORT_C_PIN_LEVEL = 16'h02d2;
  localparam logic [15:0] PORT_C_OUTPUT_LATCH = 16'h02d4;
  localparam logic [15:0] PORT_C_OPEN_DRAIN = 16'h02d6;
  localparam logic [15:0] PORT_D_DIRECTION = 16'h02d8;
  localparam logic [15:0] PORT_D_PIN_LEVEL = 16'h02da;
  localparam logic [15:0] PORT_D_OUTPUT_LATCH = 16'h02dc;
  localparam logic [15:0] PORT_D_OPEN_DRAIN = 16'h02de;
  localparam logic [15:0] PORT_E_DIRECTION = 16'h02e0;
  localparam logic [15:0] PORT_E_PIN_LEVEL = 16'h02e2;
  localparam logic [15:0] PORT_E_OUTPUT_LATCH = 16'h02e4;
  localparam logic [15:0] PORT_E_OPEN_DRAIN = 16'h02e6;

  // number of ports and their index in the arrays (B=0 .. E=3)
  localparam int GPX_NPORT = 4;
  localparam int GPX_PORT_C = 1;

  // field select, address bits [2:1] inside a port's group
  typedef enum logic [1:0] {
    FLD_DIR = 2'h0,
    FLD_PIN = 2'h1,
    FLD_LAT = 2'h2,
    FLD_ODC = 2'h3
  } gpx_fld_e;

  // package variant and oscillator field codes
  localparam logic [1:0] GPX_VAR_64 = 2'h0;
  localparam logic [1:0] GPX_VAR_80 = 2'h1;
  localparam logic [1:0] GPX_VAR_100 = 2'h2;
  localparam logic [1:0] GPX_OSC_EXT_CLK = 2'h0;
  localparam logic [1:0] GPX_OSC_OFF = 2'h3;

  // implemented bits on the largest package, also the direction reset
  localparam logic [3:0][15:0] GPX_IMPL_MASK =
    {16'h03ff, 16'hffff, 16'hf01e, 16'hffff};
  localparam logic [3:0][15:0] GPX_DIR_RST = GPX_IMPL_MASK;
  localparam logic [15:0] GPX_ODC_RST = 16'h0000;
  localparam logic [15:0] GPX_DATA_RST = 16'h0000;
  // bits removed on the smaller packages
  localparam logic [3:0][15:0] GPX_DROP_64 =
    {16'h0300, 16'hf000, 16'h001e, 16'h0000};
  localparam logic [3:0][15:0] GPX_DROP_80 =
    {16'h0000, 16'h0000, 16'h0014, 16'h0000};
  // port c pins that depend on the oscillator setup
  localparam logic [15:0] GPX_C_PIN12 = 16'h1000;
  localparam logic [15:0] GPX_C_PIN15 = 16'h8000;

  // write request towards one port
  typedef struct packed {
    logic en;
    gpx_fld_e fld;
    logic [15:0] data;
  } gpx_wr_s;

  // pad drive of one port
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } gpx_pads_s;
endpackage

// >>> rtl/gpx_port.sv
module gpx_port
  import gpx_pkg::*;
#(
  parameter logic [15:0] DIR_RESET = 16'hffff
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access
  input wire gpx_wr_s wr,
  input wire logic [15:0] mask,
  // pins
  input wire logic [15:0] pad_in,
  // state for read back
  output logic [15:0] dir_q,
  output logic [15:0] lat_q,
  output logic [15:0] odc_q,
  output logic [15:0] pin_q,
  output gpx_pads_s pads
);
  logic [15:0] dir_reg;
  logic [15:0] lat_reg;
  logic [15:0] odc_reg;
  logic [15:0] pin_reg;

  // direction: only implemented bits take a write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      dir_reg <= DIR_RESET;
    else if (wr.en && wr.fld == FLD_DIR)
      dir_reg <= (wr.data & mask) | (dir_reg & ~mask);
  end

  // latch: a write to the pin level lands here too
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_reg <= GPX_DATA_RST;
    else if (wr.en && (wr.fld == FLD_LAT || wr.fld == FLD_PIN))
      lat_reg <= (wr.data & mask) | (lat_reg & ~mask);
  end

  // open drain control
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      odc_reg <= GPX_ODC_RST;
    else if (wr.en && wr.fld == FLD_ODC)
      odc_reg <= (wr.data & mask) | (odc_reg & ~mask);
  end

  // pin level sample, absent pins never show a level
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_reg <= GPX_DATA_RST;
    else
      pin_reg <= pad_in & mask;
  end

  // read back masked so removed bits read zero at once
  assign dir_q = dir_reg & mask;
  assign lat_q = lat_reg & mask;
  assign odc_q = odc_reg & mask;
  assign pin_q = pin_reg & mask;

  // drive: output when direction is 0; open drain never drives high
  assign pads.out = lat_reg & mask;
  assign pads.oe = mask & ~dir_reg & ~(odc_reg & lat_reg);
endmodule

// >>> tb/gpx_pin_model.sv
module gpx_pin_model
(
  // drive from the port block
  input wire logic [3:0][15:0] pad_out,
  input wire logic [3:0][15:0] pad_oe,
  // levels the board puts on undriven pins
  input wire logic [3:0][15:0] ext_level,
  // levels seen back at the pads
  output logic [3:0][15:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven pins follow drive
  // a released open-drain pin falls back to the board level
  assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule

// >>> tb/tb.sv
module tb
  import gpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic [1:0] var_sel = GPX_VAR_100;
  logic [1:0] osc_cfg = GPX_OSC_EXT_CLK;
  logic osc_fn = 1'b1;
  logic [3:0][15:0] ext_level = '0;
  logic [3:0][15:0] pad_in;
  logic [3:0][15:0] pad_out;
  logic [3:0][15:0] pad_oe;
  int mismatches = 0;
  int check_count = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  gpx_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pkg_variant_sel(var_sel),
    .primary_osc_config_field(osc_cfg),
    .osc_output_function_bit(osc_fn), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe)
  );

  gpx_pin_model board (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
    .pad_in(pad_in)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // four-state compare so an unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; takes effect at the sampling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask

  task automatic t_reset;
    rdchk(PORT_B_DIRECTION, 16'hffff);
    rdchk(PORT_C_DIRECTION, 16'hf01e);
    rdchk(PORT_D_DIRECTION, 16'hffff);
    rdchk(PORT_E_DIRECTION, 16'h03ff);
    rdchk(PORT_B_OPEN_DRAIN, 16'h0000);
    rdchk(PORT_E_OPEN_DRAIN, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_unimpl;
    wr(PORT_E_OUTPUT_LATCH, 16'hffff);
    rdchk(PORT_E_OUTPUT_LATCH, 16'h03ff);
    wr(PORT_C_OPEN_DRAIN, 16'hffff);
    rdchk(PORT_C_OPEN_DRAIN, 16'hf01e);
    wr(PORT_C_OPEN_DRAIN, 16'h0000);
    rdchk(16'h02f0, 16'h0000);
    $display("test unimplemented done");
  endtask

  task automatic t_variant;
    @(posedge sys_clk);
    var_sel <= GPX_VAR_64;
    rdchk(PORT_C_DIRECTION, 16'hf000);
    rdchk(PORT_D_DIRECTION, 16'h0fff);
    rdchk(PORT_E_DIRECTION, 16'h00ff);
    var_sel <= GPX_VAR_80;
    rdchk(PORT_C_DIRECTION, 16'hf00a);
    rdchk(PORT_D_DIRECTION, 16'hffff);
    var_sel <= GPX_VAR_100;
    rdchk(PORT_C_DIRECTION, 16'hf01e);
    $display("test variant done");
  endtask

  task automatic t_osc;
    @(posedge sys_clk);
    osc_cfg <= 2'h1;
    rdchk(PORT_C_DIRECTION, 16'h601e);
    osc_cfg <= 2'h2;
    rdchk(PORT_C_DIRECTION, 16'h601e);
    osc_cfg <= GPX_OSC_OFF;
    osc_fn <= 1'b0;
    rdchk(PORT_C_DIRECTION, 16'h701e);
    osc_fn <= 1'b1;
    rdchk(PORT_C_DIRECTION, 16'hf01e);
    $display("test oscillator done");
  endtask

  task automatic t_pins;
    wr(PORT_B_OUTPUT_LATCH, 16'ha5a5);
    wr(PORT_B_DIRECTION, 16'h0000);
    #1;
    chk(pad_out[0], 16'ha5a5);
    chk(pad_oe[0], 16'hffff);
    wr(PORT_B_OPEN_DRAIN, 16'hffff);
    #1;
    chk(pad_oe[0], 16'h5a5a);
    wr(PORT_B_OPEN_DRAIN, 16'h0000);
    wr(PORT_B_DIRECTION, 16'hffff);
    ext_level[0] <= 16'h1234;
    #1;
    chk(pad_oe[0], 16'h0000);
    repeat (2) @(posedge sys_clk);
    rdchk(PORT_B_PIN_LEVEL, 16'h1234);
    $display("test pins done");
  endtask

  // main sequence after 6 cycles of reset
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_unimpl();
    t_variant();
    t_osc();
    t_pins();
    end_sim();
  end

  // tests need well under 200 cycles; this cuts a hang short
  initial
  begin
    #50000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule
